/* rtl/eag_offset_adder.sv */
`include "eag_params.svh"
module eag_offset_adder
    import eag_pkg::*;
(
    input  wire logic [`EAG_ADDR_W-1:0] base_val,
    input  wire logic                   base_valid,
    input  wire logic [`EAG_ADDR_W-1:0] index_val,
    input  wire logic                   index_ok,
    input  wire eag_pkg::eag_scale_e    scale,
    input  wire logic [`EAG_ADDR_W-1:0] disp,
    input  wire logic                   addr32,
    output logic      [`EAG_ADDR_W-1:0] ea
);
    logic [`EAG_ADDR_W-1:0] scaled;
    logic [`EAG_ADDR_W-1:0] sum;
    always_comb begin
        // Scale only matters with an index present
        scaled = '0;
        if (index_ok) begin
            scaled = index_val << scale;
        end
        sum = disp + (base_valid ? base_val : '0) + scaled;
        // Carries past the top offset bit are dropped
        if (addr32) begin
            ea = sum;
        end else begin
            ea = {{(`EAG_ADDR_W-`EAG_OFS16_W){1'b0}},
                  sum[`EAG_OFS16_W-1:0]};
        end
    end
endmodule

/* rtl/eag_params.svh */
`ifndef EAG_PARAMS_SVH
`define EAG_PARAMS_SVH
`define EAG_ADDR_W       32
`define EAG_OFS16_W      16
`define EAG_SEL_W        16
`define EAG_PORT_W       16
`define EAG_FARPTR_W     48
`define EAG_FAR_OFS_LSB  0
`define EAG_FAR_SEL_LSB  32
`define EAG_REG_IDX_W    3
`define EAG_IDX_SP       3'h4
`define EAG_IDX_BP       3'h5
`define EAG_BYTE_BITS    8'h08
`define EAG_WORD_BITS    8'h10
`define EAG_DWORD_BITS   8'h20
`define EAG_QWORD_BITS   8'h40
`define EAG_DQWORD_BITS  8'h80
`define EAG_LANES        16
`endif

/* rtl/eag_pkg.sv */
`include "eag_params.svh"
package eag_pkg;
    typedef enum logic [2:0] {
        EAG_SEG_ES, EAG_SEG_CS, EAG_SEG_SS, EAG_SEG_DS, EAG_SEG_FS, EAG_SEG_GS
    } eag_seg_e;
    typedef enum logic [2:0] {
        EAG_REF_FETCH, EAG_REF_STACK, EAG_REF_DATA, EAG_REF_STR_DST,
        EAG_REF_SEL_EXPL, EAG_REF_FAR_PTR, EAG_REF_IO
    } eag_ref_e;
    typedef enum logic [1:0] {
        EAG_DISP_NONE, EAG_DISP_8, EAG_DISP_16, EAG_DISP_32
    } eag_disp_e;
    typedef enum logic [1:0] {
        EAG_SCALE_1, EAG_SCALE_2, EAG_SCALE_4, EAG_SCALE_8
    } eag_scale_e;
    typedef enum logic [2:0] {
        EAG_SIZE_BYTE, EAG_SIZE_WORD, EAG_SIZE_DWORD,
        EAG_SIZE_QWORD, EAG_SIZE_DQWORD
    } eag_size_e;
    typedef struct packed {
        eag_ref_e                      ref_kind;
        logic                          addr32;
        logic                          ovr_valid;
        eag_seg_e                      ovr_seg;
        logic                          base_valid;
        logic [`EAG_REG_IDX_W-1:0]     base_idx;
        logic [`EAG_ADDR_W-1:0]        base_val;
        logic                          index_valid;
        logic [`EAG_REG_IDX_W-1:0]     index_idx;
        logic [`EAG_ADDR_W-1:0]        index_val;
        eag_scale_e                    scale;
        eag_disp_e                     disp_kind;
        logic [`EAG_ADDR_W-1:0]        disp_raw;
        logic                          sel_from_mem;
        logic [`EAG_SEL_W-1:0]         sel_mem;
        logic [`EAG_SEL_W-1:0]         sel_reg;
        logic [`EAG_FARPTR_W-1:0]      far_ptr;
        logic                          port_from_imm;
        logic [7:0]                    port_imm;
        logic [`EAG_PORT_W-1:0]        data_port_reg;
        eag_size_e                     size;
        logic [127:0]                  data;
    } eag_req_s;
    typedef struct packed {
        eag_seg_e                      seg;
        logic [`EAG_ADDR_W-1:0]        offset;
        logic [`EAG_SEL_W-1:0]         selector;
        logic [`EAG_PORT_W-1:0]        port;
        logic                          index_fault;
        logic                          seg_ovr_ignored;
        logic [7:0]                    size_bits;
        logic [`EAG_LANES-1:0]         byte_en;
        logic [127:0]                  lanes;
    } eag_rsp_s;
endpackage

/* rtl/eag_top.sv */
`include "eag_params.svh"
module eag_top (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    input  wire eag_pkg::eag_req_s req,
    output logic                   rsp_valid,
    output eag_pkg::eag_rsp_s      rsp
);
    import eag_pkg::*;

    logic [`EAG_ADDR_W-1:0] disp_ext;
    logic [`EAG_ADDR_W-1:0] ea;
    logic                   index_ok;
    logic                   index_is_sp;
    eag_seg_e               seg_nxt;
    logic                   ovr_ignored_nxt;
    logic [`EAG_ADDR_W-1:0] ofs_nxt;
    logic [`EAG_SEL_W-1:0]  sel_nxt;
    logic [`EAG_PORT_W-1:0] port_nxt;
    logic [7:0]             bits_nxt;
    logic [`EAG_LANES-1:0]  be_nxt;
    logic                   rsp_valid_r;
    eag_rsp_s               rsp_r;

    function automatic logic [`EAG_ADDR_W-1:0] sext_disp(
        input eag_disp_e              kind,
        input logic [`EAG_ADDR_W-1:0] raw
    );
        logic [`EAG_ADDR_W-1:0] v;
        v = '0;
        case (kind)
            EAG_DISP_8:  v = {{24{raw[7]}}, raw[7:0]};
            EAG_DISP_16: v = {{16{raw[15]}}, raw[15:0]};
            EAG_DISP_32: v = raw;
            default:     v = '0;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] size_to_bits(input eag_size_e s);
        logic [7:0] b;
        b = `EAG_BYTE_BITS;
        case (s)
            EAG_SIZE_WORD:   b = `EAG_WORD_BITS;
            EAG_SIZE_DWORD:  b = `EAG_DWORD_BITS;
            EAG_SIZE_QWORD:  b = `EAG_QWORD_BITS;
            EAG_SIZE_DQWORD: b = `EAG_DQWORD_BITS;
            default:         b = `EAG_BYTE_BITS;
        endcase
        return b;
    endfunction

    assign disp_ext    = sext_disp(req.disp_kind, req.disp_raw);
    assign index_is_sp = req.index_idx == `EAG_IDX_SP;
    // A stack-pointer index is dropped and flagged, not summed
    assign index_ok    = req.index_valid && !index_is_sp;

    eag_offset_adder u_adder (
        .base_val   (req.base_val),
        .base_valid (req.base_valid),
        .index_val  (req.index_val),
        .index_ok   (index_ok),
        .scale      (req.scale),
        .disp       (disp_ext),
        .addr32     (req.addr32),
        .ea         (ea)
    );

    // Segment choice
    always_comb begin
        seg_nxt         = EAG_SEG_DS;
        ovr_ignored_nxt = 1'b0;
        case (req.ref_kind)
            EAG_REF_FETCH: begin
                seg_nxt         = EAG_SEG_CS;
                ovr_ignored_nxt = req.ovr_valid;
            end
            EAG_REF_STACK: begin
                seg_nxt         = EAG_SEG_SS;
                ovr_ignored_nxt = req.ovr_valid;
            end
            EAG_REF_STR_DST: begin
                seg_nxt         = EAG_SEG_ES;
                ovr_ignored_nxt = req.ovr_valid;
            end
            EAG_REF_DATA, EAG_REF_FAR_PTR: begin
                if (req.ovr_valid) begin
                    seg_nxt = req.ovr_seg;
                end else if (req.base_valid &&
                             (req.base_idx == `EAG_IDX_SP ||
                              req.base_idx == `EAG_IDX_BP)) begin
                    seg_nxt = EAG_SEG_SS;
                end else begin
                    seg_nxt = EAG_SEG_DS;
                end
            end
            default: begin
                seg_nxt = EAG_SEG_DS;
            end
        endcase
    end

    // Offset, selector and port
    always_comb begin
        ofs_nxt  = ea;
        sel_nxt  = '0;
        port_nxt = '0;
        if (req.ref_kind == EAG_REF_FAR_PTR) begin
            // Low doubleword is the offset, next word the selector
            ofs_nxt = req.far_ptr[`EAG_FAR_OFS_LSB +: `EAG_ADDR_W];
            sel_nxt = req.far_ptr[`EAG_FAR_SEL_LSB +: `EAG_SEL_W];
            if (!req.addr32) begin
                ofs_nxt = {16'h0000, ofs_nxt[`EAG_OFS16_W-1:0]};
            end
        end else if (req.ref_kind == EAG_REF_SEL_EXPL) begin
            sel_nxt = req.sel_from_mem ? req.sel_mem : req.sel_reg;
        end else if (req.ref_kind == EAG_REF_IO) begin
            ofs_nxt = '0;
            if (req.port_from_imm) begin
                port_nxt = {8'h00, req.port_imm};
            end else begin
                port_nxt = req.data_port_reg;
            end
        end
    end

    // Byte lanes: byte k of the operand sits at address + k
    always_comb begin
        bits_nxt = size_to_bits(req.size);
        be_nxt   = '0;
        for (int i = 0; i < `EAG_LANES; i++) begin
            if (i * 8 < int'(bits_nxt)) begin
                be_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= req_valid;
        end
    end

    // Result registered so every output leaves a flip-flop
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_r <= '0;
        end else if (req_valid) begin
            rsp_r.seg             <= seg_nxt;
            rsp_r.offset          <= ofs_nxt;
            rsp_r.selector        <= sel_nxt;
            rsp_r.port            <= port_nxt;
            rsp_r.index_fault     <= req.index_valid && index_is_sp;
            rsp_r.seg_ovr_ignored <= ovr_ignored_nxt;
            rsp_r.size_bits       <= bits_nxt;
            rsp_r.byte_en         <= be_nxt;
            rsp_r.lanes           <= req.data;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp       = rsp_r;

    a_fetch_code_seg: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_FETCH
        |=> rsp_valid && rsp.seg == EAG_SEG_CS)
        else $error("fetch not on code segment");
    a_stack_seg: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_STACK
        |=> rsp.seg == EAG_SEG_SS)
        else $error("push or pop not on stack segment");
    a_str_dst_es: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_STR_DST
        |=> rsp.seg == EAG_SEG_ES)
        else $error("string destination not on extra segment");
    a_ovr_applied: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.ovr_valid
        |=> rsp.seg == $past(req.ovr_seg))
        else $error("override prefix not applied");
    a_bp_base_ss: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && !req.ovr_valid
        && req.base_valid && req.base_idx == `EAG_IDX_BP
        |=> rsp.seg == EAG_SEG_SS)
        else $error("frame pointer base not on stack segment");
    a_sp_no_index: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.index_valid
        && req.index_idx == `EAG_IDX_SP && !req.base_valid
        && req.disp_kind == EAG_DISP_NONE
        |=> rsp.offset == '0 && rsp.index_fault)
        else $error("stack pointer used as index");
    a_disp8_sext: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.addr32
        && req.disp_kind == EAG_DISP_8 && !req.base_valid
        && !req.index_valid
        |=> rsp.offset == {{24{$past(req.disp_raw[7])}},
                           $past(req.disp_raw[7:0])})
        else $error("byte displacement not sign extended");
    a_offset16_trunc: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && !req.addr32 |=> rsp.offset[31:16] == 16'h0000)
        else $error("16-bit offset not truncated");
    a_far_ptr_split: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_FAR_PTR
        |=> rsp.selector == $past(req.far_ptr[47:32]))
        else $error("far pointer selector misplaced");
    a_io_port_sel: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_IO && !req.port_from_imm
        |=> rsp.port == $past(req.data_port_reg))
        else $error("port not taken from data port register");
    a_size_lanes: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.size == EAG_SIZE_DWORD
        |=> rsp.size_bits == `EAG_DWORD_BITS
            && rsp.byte_en == 16'h000F)
        else $error("doubleword size or lanes wrong");
    a_rsp_valid_set: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid |=> rsp_valid)
        else $error("response strobe missing");
    a_rsp_valid_clr: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !req_valid |=> !rsp_valid)
        else $error("response strobe without request");
    a_rsp_holds: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !req_valid |=> $stable(rsp))
        else $error("result changed without request");
    a_ovr_ignored: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ovr_valid && (req.ref_kind == EAG_REF_FETCH
        || req.ref_kind == EAG_REF_STACK || req.ref_kind == EAG_REF_STR_DST)
        |=> rsp.seg_ovr_ignored)
        else $error("fixed segment override not flagged");
    a_data_ovr_kept: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA |=> !rsp.seg_ovr_ignored)
        else $error("data override flagged as ignored");
    a_data_default_ds: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && !req.ovr_valid
        && !req.base_valid |=> rsp.seg == EAG_SEG_DS)
        else $error("plain data not on data segment");
    a_sp_base_ss: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && !req.ovr_valid
        && req.base_valid && req.base_idx == `EAG_IDX_SP
        |=> rsp.seg == EAG_SEG_SS)
        else $error("stack pointer base not on stack segment");
    a_other_base_ds: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && !req.ovr_valid
        && req.base_valid && req.base_idx != `EAG_IDX_SP
        && req.base_idx != `EAG_IDX_BP |=> rsp.seg == EAG_SEG_DS)
        else $error("general base not on data segment");
    a_far_ofs16: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_FAR_PTR && !req.addr32
        |=> rsp.offset == {16'h0000, $past(req.far_ptr[15:0])})
        else $error("far pointer offset not cut to 16 bits");
    a_sel_from_mem: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_SEL_EXPL && req.sel_from_mem
        |=> rsp.selector == $past(req.sel_mem))
        else $error("selector not taken from memory");
    a_io_port_imm: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_IO && req.port_from_imm
        |=> rsp.port == {8'h00, $past(req.port_imm)})
        else $error("port not taken from immediate");
    a_io_no_offset: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_IO |=> rsp.offset == '0)
        else $error("port access left a memory offset");
    a_scaled_index: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.addr32
        && req.index_valid && req.index_idx != `EAG_IDX_SP
        && !req.base_valid && req.disp_kind == EAG_DISP_NONE
        |=> rsp.offset == ($past(req.index_val) << $past(req.scale)))
        else $error("index not scaled");
    a_scale_needs_index: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.addr32
        && !req.index_valid && !req.base_valid
        && req.disp_kind == EAG_DISP_NONE |=> rsp.offset == '0)
        else $error("scale applied without index");
    a_base_only: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.addr32
        && req.base_valid && !req.index_valid
        && req.disp_kind == EAG_DISP_NONE
        |=> rsp.offset == $past(req.base_val))
        else $error("base alone not used as offset");
    a_disp16_sext: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.addr32
        && req.disp_kind == EAG_DISP_16 && !req.base_valid
        && !req.index_valid
        |=> rsp.offset == {{16{$past(req.disp_raw[15])}},
                           $past(req.disp_raw[15:0])})
        else $error("word displacement not sign extended");
    a_disp32_only: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.ref_kind == EAG_REF_DATA && req.addr32
        && req.disp_kind == EAG_DISP_32 && !req.base_valid
        && !req.index_valid |=> rsp.offset == $past(req.disp_raw))
        else $error("doubleword displacement altered");
    a_byte_lanes: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.size == EAG_SIZE_BYTE
        |=> rsp.size_bits == `EAG_BYTE_BITS
            && rsp.byte_en == 16'h0001)
        else $error("byte size or lane wrong");
    a_qword_lanes: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid && req.size == EAG_SIZE_QWORD
        |=> rsp.size_bits == `EAG_QWORD_BITS
            && rsp.byte_en == 16'h00FF)
        else $error("quadword size or lanes wrong");
    a_lanes_pass: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        req_valid |=> rsp.lanes == $past(req.data))
        else $error("operand bytes reordered");
endmodule

/* verification/eag_req_driver.sv */
`include "eag_params.svh"
module eag_req_driver
    import eag_pkg::*;
(
    input  wire logic              sys_clk,
    output logic                   req_valid,
    output eag_pkg::eag_req_s      req,
    input  wire logic              rsp_valid,
    input  wire eag_pkg::eag_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    // One request, held through its taking edge, then released
    task automatic issue(input eag_req_s r, output eag_rsp_s got,
                         output bit ok);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b1;
        req = r;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        // Released fields scrambled so a stale sample cannot look right
        req = eag_req_s'(~r);
        ok = (rsp_valid === 1'b1);
        got = rsp;
        @(posedge sys_clk);
        #1;
        ok = ok && (rsp_valid === 1'b0) && (rsp === got);
    endtask
endmodule

/* verification/eag_top_test.sv */
`include "eag_params.svh"
module eag_top_test;
    import eag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic     sys_clk;
    logic     reset_n;
    logic     req_valid;
    logic     rsp_valid;
    eag_req_s req;
    eag_rsp_s rsp;
    int       fails;
    int       n_compared;

    eag_top dut_u (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .req_valid (req_valid),
        .req       (req),
        .rsp_valid (rsp_valid),
        .rsp       (rsp)
    );

    eag_req_driver model_u (
        .sys_clk   (sys_clk),
        .req_valid (req_valid),
        .req       (req),
        .rsp_valid (rsp_valid),
        .rsp       (rsp)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [127:0] seen,
                         input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic run(input eag_req_s r, output eag_rsp_s g);
        bit ok;
        model_u.issue(r, g, ok);
        check("rsp_valid", ok, 1'b1);
    endtask

    function automatic eag_req_s blank(eag_ref_e k);
        eag_req_s r;
        r = '0;
        r.ref_kind = k;
        r.addr32 = 1'b1;
        return r;
    endfunction

    function automatic logic [31:0] exp_ea(eag_req_s r);
        logic [31:0] d;
        logic [31:0] s;
        case (r.disp_kind)
            EAG_DISP_8:  d = {{24{r.disp_raw[7]}}, r.disp_raw[7:0]};
            EAG_DISP_16: d = {{16{r.disp_raw[15]}}, r.disp_raw[15:0]};
            EAG_DISP_32: d = r.disp_raw;
            default:     d = 32'h0;
        endcase
        s = d + (r.base_valid ? r.base_val : 32'h0);
        if (r.index_valid && r.index_idx != `EAG_IDX_SP) begin
            s = s + (r.index_val << r.scale);
        end
        return r.addr32 ? s : {16'h0, s[15:0]};
    endfunction

    task automatic t_segment();
        eag_req_s r;
        eag_rsp_s g;
        eag_ref_e k[4] = '{EAG_REF_FETCH, EAG_REF_STACK, EAG_REF_STR_DST,
                           EAG_REF_DATA};
        eag_seg_e d[4] = '{EAG_SEG_CS, EAG_SEG_SS, EAG_SEG_ES, EAG_SEG_DS};
        for (int i = 0; i < 4; i++) begin
            for (int o = 0; o < 2; o++) begin
                r = blank(k[i]);
                r.ovr_valid = o[0];
                r.ovr_seg = EAG_SEG_FS;
                run(r, g);
                check("seg", g.seg, (o == 1 && i == 3) ? EAG_SEG_FS : d[i]);
                check("ovr_ignored", g.seg_ovr_ignored, o == 1 && i < 3);
            end
        end
        for (int b = 0; b < 8; b++) begin
            r = blank(EAG_REF_DATA);
            r.base_valid = 1'b1;
            r.base_idx = b[2:0];
            run(r, g);
            check("base seg", g.seg, (b == 4 || b == 5) ? EAG_SEG_SS
                                                        : EAG_SEG_DS);
        end
        $display("test segment done");
    endtask

    task automatic t_offset();
        eag_req_s r;
        eag_rsp_s g;
        // Passes: base and index, index, none, stack index, base
        for (int v = 0; v < 5; v++) begin
            for (int k = 0; k < 8; k++) begin
                for (int s = 0; s < 4; s++) begin
                    r = blank(EAG_REF_DATA);
                    r.addr32 = k[2];
                    r.disp_kind = eag_disp_e'(k[1:0]);
                    r.disp_raw = 32'h1234_8081;
                    r.base_valid = (v == 0 || v == 4);
                    r.base_val = 32'hFFFF_FFF0;
                    r.index_valid = (v < 2 || v == 3);
                    r.index_idx = (v == 3) ? `EAG_IDX_SP : 3'h1;
                    r.index_val = 32'h8000_0013;
                    r.scale = eag_scale_e'(s[1:0]);
                    run(r, g);
                    check("offset", g.offset, exp_ea(r));
                    check("index_fault", g.index_fault, v == 3);
                end
            end
        end
        $display("test offset done");
    endtask

    task automatic t_far_io();
        eag_req_s r;
        eag_rsp_s g;
        r = blank(EAG_REF_FAR_PTR);
        r.far_ptr = 48'hBEEF_8765_4321;
        r.ovr_valid = 1'b1;
        r.ovr_seg = EAG_SEG_GS;
        run(r, g);
        check("far offset", g.offset, 32'h8765_4321);
        check("far selector", g.selector, 16'hBEEF);
        check("far seg", g.seg, EAG_SEG_GS);
        r.addr32 = 1'b0;
        run(r, g);
        check("far offset16", g.offset, 32'h0000_4321);
        for (int m = 0; m < 2; m++) begin
            r = blank(EAG_REF_SEL_EXPL);
            r.sel_from_mem = m[0];
            r.sel_mem = 16'hA5C3;
            r.sel_reg = 16'h5A3C;
            run(r, g);
            check("selector", g.selector, m ? 16'hA5C3 : 16'h5A3C);
            r = blank(EAG_REF_IO);
            r.port_from_imm = m[0];
            r.port_imm = 8'hF7;
            r.data_port_reg = 16'hFFFF;
            run(r, g);
            check("port", g.port, m ? 16'h00F7 : 16'hFFFF);
        end
        $display("test far and io done");
    endtask

    task automatic t_size();
        eag_req_s r;
        eag_rsp_s g;
        for (int i = 0; i < 5; i++) begin
            r = blank(EAG_REF_DATA);
            r.size = eag_size_e'(i[2:0]);
            r.data = 128'h0F0E_0D0C_0B0A_0908_0706_0504_0302_0100;
            run(r, g);
            check("size_bits", g.size_bits, 8'h08 << i);
            check("byte_en", g.byte_en, 16'hFFFF >> (16 - (1 << i)));
            check("lanes", g.lanes, r.data);
        end
        $display("test size done");
    endtask

    task automatic t_reset();
        eag_rsp_s g;
        run(blank(EAG_REF_STACK), g);
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("reset valid", rsp_valid, 1'b0);
        check("reset rsp", rsp === '0, 1'b1);
        reset_n = 1'b1;
        run(blank(EAG_REF_FETCH), g);
        check("after reset seg", g.seg, EAG_SEG_CS);
        $display("test reset done");
    endtask

    task automatic final_report();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // About 190 requests of three cycles each; generous margin
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        final_report();
    end

    initial begin
        fails = 0;
        n_compared = 0;
        reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("idle valid", rsp_valid, 1'b0);
        reset_n = 1'b1;
        t_segment();
        t_offset();
        t_far_io();
        t_size();
        t_reset();
        final_report();
    end
endmodule
